/* File: rtl/adc_core_seq.sv */
// Converter core sequencer: prescaler, clock counting, sample and hold.
// Assumes start only arrives while idle and power is high.
`timescale 1ns/100ps
module adc_core_seq
   import adc_pkg::*;
#(
   parameter int CNT_W = 7  // Prescaler counter width
)
(
   input wire logic clk,      // System clock
   input wire logic sys_rst,  // Async reset, active high
   conv_if.core cv            // Link to control side
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      core_e state;           // Sequencer state
      logic [CNT_W-1:0] pre;  // Prescaler count
      logic [4:0] clks;       // Converter clocks left
      logic [9:0] held;       // Sampled value
      logic done;             // Completion strobe
      logic [9:0] result;     // Returned result
   } core_s;
   core_s q_reg;
   core_s q_next;
   logic tick;  // One converter clock elapsed

   // Refuse a counter too short for divide by 128
   generate
      if (CNT_W < 7)
      begin : g_chk
         $error("CNT_W must be at least 7");
      end
   endgenerate

   // Mask whose all-ones marks the end of one converter clock
   function automatic logic [CNT_W-1:0] div_mask(input logic [2:0] d);
      logic [3:0] k;
      k = (d < 3'h2) ? 4'h1 : {1'h0, d};
      div_mask = CNT_W'((1 << k) - 1);
   endfunction

   // Next state
   always_comb
   begin
      q_next = q_reg;
      q_next.done = 1'h0;
      tick = (q_reg.pre & div_mask(cv.divider)) == div_mask(cv.divider);
      case (q_reg.state)
         CORE_IDLE:
         begin
            // Prescaler held so conversion clocks align to the start
            q_next.pre = '0;
            if (cv.start && cv.power)
            begin
               q_next.state = CORE_RUN;
               q_next.clks = cv.long_conv ? FIRST_CONV_CLKS : NORMAL_CONV_CLKS;
            end
         end
         CORE_RUN:
         begin
            q_next.pre = q_reg.pre + 1'h1;
            if (tick)
            begin
               q_next.clks = q_reg.clks - 5'h01;
               if (q_reg.clks == SAMPLE_LEFT)
                  q_next.held = cv.sample;
               if (q_reg.clks == 5'h01)
               begin
                  q_next.state = CORE_IDLE;
                  q_next.result = q_reg.held;
                  q_next.done = 1'h1;
               end
            end
         end
         default:
            q_next.state = CORE_IDLE;
      endcase
      // Power loss drops the conversion without a strobe
      if (!cv.power)
      begin
         q_next.state = CORE_IDLE;
         q_next.done = 1'h0;
      end
   end

   // State register
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         q_reg <= '0;
      else
         q_reg <= q_next;
   end

   assign cv.done = q_reg.done;
   assign cv.result = q_reg.result;

   // Shortest conversion at divide by 2 ends 27 cycles after start
   AST_CONV_LENGTH: assert property (@(posedge clk) disable iff (sys_rst)
      (cv.start && cv.power && !cv.long_conv && cv.divider == 3'h0 && q_reg.state == CORE_IDLE)
      |-> ##27 (cv.done || !cv.power))
      else $error("short conversion length wrong");
   AST_NO_DONE_UNPOWERED: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(cv.power) |=> !cv.done)
      else $error("done after power loss");
endmodule

/* File: rtl/adc_ctrl.sv */
// Converter control block: selection and control registers, triggering,
// result holding and interrupts, with the core sequencer below it.
// Assumes the register master never issues read and write together.
`timescale 1ns/100ps
module adc_ctrl
   import adc_pkg::*;
(
   input wire logic clk,                // System clock 100 MHz
   input wire logic sys_rst,            // Async reset, active high
   input wire logic [2:0] addr,         // Register address
   input wire logic [7:0] wdata,        // Write data
   input wire logic wr,                 // Write strobe
   input wire logic rd,                 // Read strobe
   output logic [7:0] rdata,            // Read data, cycle after rd
   input wire logic global_irq_enable,  // CPU global enable bit
   input wire logic irq_ack,            // Completion vector executed
   input wire logic [6:0] trigger_in,   // Trigger sources 1..7
   input wire logic [9:0] analog_in,    // Digitised analog value
   output logic converter_power,        // Converter powered
   output logic [1:0] reference_out,    // Active reference code
   output logic internal_ref_on,        // 2.56V reference on
   output logic [2:0] mux_pos,          // Positive input index
   output logic [2:0] mux_neg,          // Negative input index
   output adc_pkg::gain_e mux_gain,     // Amplifier gain
   output logic mux_diff,               // Differential pair
   output logic mux_bandgap,            // Bandgap selected
   output logic mux_ground,             // Ground selected
   output logic conv_irq,               // Completion interrupt
   output logic irq                     // Masked status interrupt
);
   import adc_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] sel;      // Input select register
      logic [1:0] act_ref;  // Reference in use
      logic [4:0] act_ch;   // Channel in use
      logic en;             // Converter enable
      logic busy;           // Conversion running
      logic ate;            // Auto-trigger enable
      logic flag;           // Conversion done flag
      logic ie;             // Completion interrupt enable
      logic [2:0] ps;       // Prescaler code
      logic first;          // Next conversion is extended
      logic start;          // Start pulse to core
      logic long_conv;      // Extended flag to core
      logic [9:0] result;   // Held result
      logic locked;         // Result frozen by low read
      logic [2:0] trig_src; // Trigger source select
      logic trig_prev;      // Previous trigger level
      logic [1:0] ist;      // Sticky event status
      logic [1:0] imask;    // Event mask
      logic [7:0] rdata;    // Read data
      logic conv_irq;       // Completion interrupt
      logic irq;            // Status interrupt
      logic [9:0] sync1;    // Analog first stage
      logic [9:0] sync2;    // Analog second stage
      logic int_ref;        // Internal reference on
      mux_s mux;            // Decoded input routing
   } ctrl_s;
   ctrl_s q_reg;
   ctrl_s q_next;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   logic wr_sel;     // Write to input select
   logic wr_ctl;     // Write to control
   logic rd_lo;      // Read of low result byte
   logic rd_hi;      // Read of high result byte
   logic en_now;     // Enable after this cycle
   logic en_rise;    // Enable written from zero to one
   logic busy_eff;   // Busy and not ending now
   logic trig_lvl;   // Selected trigger level
   logic auto_go;    // Auto-trigger request
   logic go;         // Start a conversion
   logic done_ok;    // Valid completion this cycle
   logic lost;       // Completion dropped while locked
   logic flag_clr;   // Flag clear request
   logic [7:0] lo_b; // Low byte view
   logic [7:0] hi_b; // High byte view

   conv_if cv ();

   // Channel code to input routing
   function automatic mux_s decode_ch(input logic [4:0] c);
      mux_s m;
      m = '0;
      m.gain = GAIN_1X;
      if (c[4:3] == 2'h0)
         m.pos = c[2:0];
      else if (c[4:3] == 2'h1)
      begin
         // Pairs share negative input 0 or 2; bit 1 picks high gain
         m.diff = 1'h1;
         m.neg = c[2] ? 3'h2 : 3'h0;
         m.pos = m.neg | {2'h0, c[0]};
         m.gain = c[1] ? GAIN_200X : GAIN_10X;
      end
      else if (c == CH_BANDGAP)
         m.bg = 1'h1;
      else if (c == CH_GROUND)
         m.gnd = 1'h1;
      else
      begin
         // Unity-gain pairs against input 1 or input 2
         m.diff = 1'h1;
         m.neg = c[3] ? 3'h2 : 3'h1;
         m.pos = c[2:0];
      end
      decode_ch = m;
   endfunction

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb
   begin
      q_next = q_reg;
      q_next.start = 1'h0;
      q_next.rdata = 8'h00;
      // Analog value comes from another domain
      q_next.sync1 = analog_in;
      q_next.sync2 = q_reg.sync1;

      wr_sel = wr && addr == OFS_INPUT_SELECT;
      wr_ctl = wr && addr == OFS_CONTROL_STATUS;
      rd_lo = rd && addr == OFS_RESULT_LOW;
      rd_hi = rd && addr == OFS_RESULT_HIGH;

      // Register writes
      if (wr_sel)
         q_next.sel = wdata;
      if (wr_ctl)
      begin
         q_next.en = wdata[EN_BIT];
         q_next.ate = wdata[ATE_BIT];
         q_next.ie = wdata[IE_BIT];
         q_next.ps = wdata[PS_HI:0];
      end
      if (wr && addr == OFS_TRIGGER_SOURCE)
         q_next.trig_src = wdata[2:0];
      if (wr && addr == OFS_IRQ_MASK)
         q_next.imask = wdata[1:0];

      en_now = q_next.en;
      en_rise = en_now && !q_reg.en;
      busy_eff = q_reg.busy && !cv.done;

      // Trigger edge; switching source may itself make an edge
      trig_lvl = 1'h0;
      if (q_reg.trig_src != TRIG_FREE_RUN)
         trig_lvl = trigger_in[q_reg.trig_src - 3'h1];
      q_next.trig_prev = trig_lvl;
      // Free running restarts on completion only, never on a switch
      if (q_reg.trig_src == TRIG_FREE_RUN)
         auto_go = q_reg.ate && cv.done && q_reg.busy;
      else
         auto_go = q_reg.ate && trig_lvl && !q_reg.trig_prev;

      // Completion
      done_ok = cv.done && q_reg.busy && en_now;
      lost = done_ok && q_reg.locked;
      if (done_ok)
      begin
         q_next.busy = 1'h0;
         if (!q_reg.locked)
            q_next.result = cv.result;
      end

      // Start: a start while busy and not ending this cycle is simply dropped
      go = en_now && !busy_eff && ((wr_ctl && wdata[START_BIT]) || auto_go);
      if (go)
      begin
         q_next.start = 1'h1;
         q_next.busy = 1'h1;
         q_next.long_conv = q_reg.first || en_rise;
         q_next.first = 1'h0;
      end
      else if (en_rise)
         q_next.first = 1'h1;

      // Disable aborts and forgets the pending extended start
      if (!en_now)
      begin
         q_next.busy = 1'h0;
         q_next.first = 1'h0;
      end

      // Selection takes effect only between conversions
      if (go || !busy_eff)
      begin
         q_next.act_ref = q_next.sel[REF_HI:REF_LO];
         q_next.act_ch = q_next.sel[CH_HI:0];
      end
      q_next.int_ref = q_next.act_ref == REF_INTERNAL;
      q_next.mux = decode_ch(q_next.act_ch);

      // Done flag: setting wins over clearing
      flag_clr = (wr_ctl && wdata[FLAG_BIT]) || irq_ack;
      q_next.flag = (q_reg.flag && !flag_clr) || done_ok;
      q_next.conv_irq = q_next.flag && q_next.ie && global_irq_enable;

      // Justification applies to the read view only
      lo_b = q_reg.sel[LJ_BIT] ? {q_reg.result[1:0], 6'h00} : q_reg.result[7:0];
      hi_b = q_reg.sel[LJ_BIT] ? q_reg.result[9:2] : {6'h00, q_reg.result[9:8]};

      // Low read freezes result, high read releases it
      if (rd_lo)
         q_next.locked = 1'h1;
      if (rd_hi)
         q_next.locked = 1'h0;

      // Read mux; unmapped addresses read zero
      if (rd)
      begin
         case (addr)
            OFS_INPUT_SELECT: q_next.rdata = q_reg.sel;
            OFS_CONTROL_STATUS: q_next.rdata = {q_reg.en, q_reg.busy, q_reg.ate, q_reg.flag,
                                                q_reg.ie, q_reg.ps};
            OFS_RESULT_LOW: q_next.rdata = lo_b;
            OFS_RESULT_HIGH: q_next.rdata = hi_b;
            OFS_TRIGGER_SOURCE: q_next.rdata = {5'h00, q_reg.trig_src};
            OFS_IRQ_STATUS: q_next.rdata = {6'h00, q_reg.ist};
            OFS_IRQ_MASK: q_next.rdata = {6'h00, q_reg.imask};
            default: q_next.rdata = 8'h00;
         endcase
      end

      // Sticky events; a read clears them but a new event survives
      if (rd && addr == OFS_IRQ_STATUS)
         q_next.ist = 2'h0;
      q_next.ist[IST_DONE] = q_next.ist[IST_DONE] || done_ok;
      q_next.ist[IST_LOST] = q_next.ist[IST_LOST] || lost;
      q_next.irq = |(q_next.ist & q_next.imask);
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         q_reg <= '0;
         q_reg.sel <= INPUT_SELECT_RST;
         q_reg.trig_src <= TRIG_SRC_RST;
         q_reg.imask <= IRQ_MASK_RST;
      end
      else
         q_reg <= q_next;
   end

   // ----------------------------------------
   // Core and outputs
   // ----------------------------------------
   assign cv.start = q_reg.start;
   assign cv.long_conv = q_reg.long_conv;
   assign cv.power = q_reg.en;
   assign cv.divider = q_reg.ps;
   assign cv.sample = q_reg.sync2;

   adc_core_seq #(.CNT_W(7)) u_core (
      .clk(clk),
      .sys_rst(sys_rst),
      .cv(cv.core)
   );

   assign rdata = q_reg.rdata;
   assign converter_power = q_reg.en;
   assign reference_out = q_reg.act_ref;
   assign internal_ref_on = q_reg.int_ref;
   assign mux_pos = q_reg.mux.pos;
   assign mux_neg = q_reg.mux.neg;
   assign mux_gain = q_reg.mux.gain;
   assign mux_diff = q_reg.mux.diff;
   assign mux_bandgap = q_reg.mux.bg;
   assign mux_ground = q_reg.mux.gnd;
   assign conv_irq = q_reg.conv_irq;
   assign irq = q_reg.irq;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   AST_REF_DECODE: assert property ((wr_sel && !q_reg.busy) |=>
      internal_ref_on == ($past(wdata[REF_HI:REF_LO]) == REF_INTERNAL))
      else $error("reference decode wrong");
   AST_SEL_HELD: assert property ((q_reg.busy && !cv.done && en_now) |=>
      $stable(q_reg.act_ch) && $stable(q_reg.act_ref))
      else $error("selection changed mid conversion");
   AST_JUSTIFY: assert property ((rd_hi && q_reg.sel[LJ_BIT]) |=>
      rdata == $past(q_reg.result[9:2]))
      else $error("left justified high byte wrong");
   AST_BANDGAP: assert property ((q_reg.act_ch == CH_BANDGAP) |->
      mux_bandgap && !mux_diff && !mux_ground)
      else $error("bandgap routing wrong");
   AST_DIFF_GAIN: assert property ((q_reg.act_ch[4:3] == 2'h1) |->
      mux_diff && mux_gain == (q_reg.act_ch[1] ? GAIN_200X : GAIN_10X))
      else $error("differential gain wrong");
   AST_UNITY_NEG: assert property ((q_reg.act_ch[4:3] == 2'h2) |->
      mux_neg == 3'h1 && mux_gain == GAIN_1X)
      else $error("unity pair routing wrong");
   AST_ABORT: assert property ($fell(q_reg.en) |-> !q_reg.busy)
      else $error("conversion survived disable");
   AST_START: assert property ((wr_ctl && wdata[START_BIT] && wdata[EN_BIT] && !q_reg.busy)
      |=> q_reg.busy && cv.start)
      else $error("start not taken");
   AST_FLAG_SET: assert property ((cv.done && q_reg.busy && en_now) |=> q_reg.flag)
      else $error("done flag not set");
   AST_FLAG_ACK: assert property ((irq_ack && !cv.done) |=> !q_reg.flag)
      else $error("flag not cleared by vector");
   AST_IRQ: assert property (conv_irq |-> q_reg.flag && q_reg.ie)
      else $error("interrupt without cause");
   AST_LOCK: assert property ((q_reg.locked && cv.done) |=> $stable(q_reg.result))
      else $error("locked result overwritten");
   AST_NO_RESTART: assert property ((q_reg.busy && !cv.done) |=> !cv.start)
      else $error("restart while busy");

   COV_LONG: cover property (cv.start && cv.long_conv ##[1:1000] cv.done);
   COV_FREE_RUN: cover property (q_reg.ate && cv.done ##1 cv.start);
   COV_LOST: cover property (q_reg.locked && cv.done && q_reg.busy);
   COV_ABORT: cover property (q_reg.busy ##1 !q_reg.en);
endmodule

/* File: rtl/adc_pkg.sv */
// Constants, types and register map of the converter control block.
// Assumes a single 100 MHz clock and an 8-bit register port with 3-bit addresses.
package adc_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [2:0] OFS_INPUT_SELECT = 3'h0;
   localparam logic [2:0] OFS_CONTROL_STATUS = 3'h1;
   localparam logic [2:0] OFS_RESULT_LOW = 3'h2;
   localparam logic [2:0] OFS_RESULT_HIGH = 3'h3;
   localparam logic [2:0] OFS_TRIGGER_SOURCE = 3'h4;
   localparam logic [2:0] OFS_IRQ_STATUS = 3'h5;
   localparam logic [2:0] OFS_IRQ_MASK = 3'h6;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int REF_HI = 7;
   localparam int REF_LO = 6;
   localparam int LJ_BIT = 5;
   localparam int CH_HI = 4;
   localparam int EN_BIT = 7;
   localparam int START_BIT = 6;
   localparam int ATE_BIT = 5;
   localparam int FLAG_BIT = 4;
   localparam int IE_BIT = 3;
   localparam int PS_HI = 2;
   localparam int IST_DONE = 0;
   localparam int IST_LOST = 1;
   // ----------------------------------------
   // Reset values and codes
   // ----------------------------------------
   localparam logic [7:0] INPUT_SELECT_RST = 8'h00;
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [2:0] TRIG_SRC_RST = 3'h0;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;
   localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
   localparam logic [1:0] REF_EXTERNAL = 2'h0;
   localparam logic [1:0] REF_SUPPLY = 2'h1;
   localparam logic [1:0] REF_INTERNAL = 2'h3;
   localparam logic [4:0] CH_BANDGAP = 5'h1E;
   localparam logic [4:0] CH_GROUND = 5'h1F;
   // ----------------------------------------
   // Timing counts in converter clocks
   // ----------------------------------------
   localparam logic [4:0] FIRST_CONV_CLKS = 5'h19;
   localparam logic [4:0] NORMAL_CONV_CLKS = 5'h0D;
   localparam logic [4:0] SAMPLE_LEFT = 5'h0C;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {GAIN_1X = 2'h0, GAIN_10X = 2'h1, GAIN_200X = 2'h2} gain_e;
   typedef enum logic {CORE_IDLE = 1'h0, CORE_RUN = 1'h1} core_e;
   typedef struct packed {
      logic [2:0] pos;  // Positive input index
      logic [2:0] neg;  // Negative input index
      gain_e gain;      // Amplifier gain
      logic diff;       // Differential pair selected
      logic bg;         // Bandgap selected
      logic gnd;        // Ground selected
   } mux_s;
endpackage

/* File: rtl/conv_if.sv */
// Link between the register side and the converter core sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface conv_if;
   logic start;          // One-cycle start request
   logic long_conv;      // Extended first conversion
   logic power;          // Converter powered
   logic [2:0] divider;  // Prescaler code
   logic [9:0] sample;   // Synchronised analog value
   logic done;           // One-cycle completion strobe
   logic [9:0] result;   // Result valid with done
   modport ctrl (output start, long_conv, power, divider, sample, input done, result);
   modport core (input start, long_conv, power, divider, sample, output done, result);
endinterface

/* File: verif/analog_model.sv */
// Far-side model: analog inputs and multiplexer seen through the selection.
// Assumes the control block drives the mux outputs from flops on one clock.
`timescale 1ns/100ps
module analog_model
   import adc_pkg::*;
#(
   parameter logic [9:0] BG_CODE = 10'h2A5  // Bandgap level, value is arbitrary
)
(
   power,      // Converter powered
   mux_pos,    // Positive input index
   mux_bg,     // Bandgap selected
   mux_gnd,    // Ground selected
   analog_in   // Digitised level
);
   input wire logic power;
   input wire logic [2:0] mux_pos;
   input wire logic mux_bg;
   input wire logic mux_gnd;
   output logic [9:0] analog_in;
   // Each positive index, the bandgap and ground give distinct levels so a wrong route shows
   assign analog_in = !power ? 10'h155 : mux_gnd ? 10'h000 : mux_bg ? BG_CODE : {mux_pos, 7'h2B};
endmodule

/* File: verif/tb_top.sv */
// Testbench of the converter control block: selection table, then conversions.
// Assumes the register port and strobes of the design's top module.
`timescale 1ns/100ps
module tb_top;
   import adc_pkg::*;
   logic clk = 0, sys_rst = 1, wr = 0, rd = 0, gie = 1, ack = 0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic [6:0] trig = 7'h00;
   logic [9:0] ain;
   logic [7:0] rdata;
   logic pwr, iref, diff, bg, gnd, conv_irq, irq;
   logic [1:0] ref_o;
   logic [2:0] pos, neg;
   gain_e gain;
   int n_errors = 0, tests_run = 0, cyc = 0;
   logic [12:0] got, msk;
   realtime t1;  // Start time of the free-run test
   // Rows: written selection byte, then ref, pos, neg, gain, diff, bg, gnd
   // Bandgap row comes last so the conversions that follow read a known level
   logic [20:0] rows [10] = '{{8'h03, 13'h0300}, {8'h47, 13'h0F00}, {8'hC8, 13'h180C},
      {8'h8B, 13'h1114}, {8'h0D, 13'h034C}, {8'h0F, 13'h0354}, {8'h17, 13'h0724},
      {8'h1D, 13'h0544}, {8'h1F, 13'h0001}, {8'h1E, 13'h0002}};
   always #5 clk = ~clk;
   adc_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .global_irq_enable(gie), .irq_ack(ack), .trigger_in(trig), .analog_in(ain),
      .converter_power(pwr), .reference_out(ref_o), .internal_ref_on(iref), .mux_pos(pos),
      .mux_neg(neg), .mux_gain(gain), .mux_diff(diff), .mux_bandgap(bg), .mux_ground(gnd),
      .conv_irq(conv_irq), .irq(irq));
   analog_model u_far (.power(pwr), .mux_pos(pos), .mux_bg(bg), .mux_gnd(gnd), .analog_in(ain));
   // --------------------------------
   // Checks and bus tasks
   // --------------------------------
   task automatic chk(input bit ok, input string m);
      tests_run++;
      if (!ok)
      begin
         n_errors++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk) begin addr <= a; wdata <= d; wr <= 1; end
      @(posedge clk) wr <= 0;
   endtask
   task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk) begin addr <= a; rd <= 1; end
      @(posedge clk) rd <= 0;
      #1 chk(rdata === e, "read data");
   endtask
   // Wait for the interrupt and check elapsed cycles since t0
   task automatic wait_irq(input realtime t0, input int lo);
      int n;
      n = 0;
      while (conv_irq !== 1'b1 && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
      n = int'(($time - t0) / 10);
      chk(n >= lo && n <= lo + 8, "conversion length");
   endtask
   // Start, repeat the start mid-run (ignored), then clear the flag
   task automatic conv(input logic [7:0] c, input int lo);
      realtime t0;
      t0 = $time;
      wr_reg(1, c);
      repeat (6) @(posedge clk);
      wr_reg(1, c);
      wait_irq(t0, lo);
      rd_reg(1, (c & 8'hBF) | 8'h10);
      wr_reg(1, 8'h98);
      repeat (3) @(posedge clk);
      chk(conv_irq === 1'b0, "flag clear");
      $display("conversion test done");
   endtask
   task automatic results;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         results();
      end
   end
   // --------------------------------
   // Main sequence
   // --------------------------------
   initial
   begin
      repeat (10) @(posedge clk);
      sys_rst <= 0;
      rd_reg(0, 8'h00);
      rd_reg(1, 8'h00);
      rd_reg(7, 8'h00);
      $display("reset test done");
      foreach (rows[i])
      begin
         wr_reg(0, rows[i][20:13]);
         repeat (2) @(posedge clk);
         got = {ref_o, pos, neg, gain, diff, bg, gnd};
         // Single ended checks the positive index; the negative one is unused then
         msk = rows[i][2] ? 13'h1FFF : (rows[i][1:0] != 0) ? 13'h181F : 13'h1F1F;
         chk((got & msk) === (rows[i][12:0] & msk), "selection");
         chk(iref === (rows[i][12:11] == 2'b11), "internal ref");
      end
      $display("selection table done");
      wr_reg(6, 8'h01);
      conv(8'hC8, 50);
      rd_reg(5, 8'h01);
      chk(irq === 1'b0, "status irq after read");
      rd_reg(2, 8'hA5);
      rd_reg(3, 8'h02);
      wr_reg(0, 8'h3E);
      rd_reg(2, 8'h40);
      rd_reg(3, 8'hA9);
      for (int k = 1; k < 4; k++)
         conv(8'hC8 | k[7:0], 13 * (2 ** k));
      wr_reg(1, 8'hC8);
      repeat (10) @(posedge clk);
      wr_reg(1, 8'h08);
      repeat (40) @(posedge clk);
      rd_reg(1, 8'h08);
      chk(pwr === 1'b0, "power off");
      wr_reg(4, 8'h01);
      wr_reg(1, 8'hA8);
      trig <= 7'h01;
      // Enable was cleared above, so this triggered conversion is the long one
      wait_irq($time, 50);
      rd_reg(5, 8'h01);
      @(posedge clk) gie <= 0;
      repeat (3) @(posedge clk);
      chk(conv_irq === 1'b0, "global enable off");
      ack <= 1;
      @(posedge clk) ack <= 0;
      gie <= 1;
      repeat (3) @(posedge clk);
      chk(conv_irq === 1'b0, "vector clears flag");
      wr_reg(4, 8'h00);
      repeat (40) @(posedge clk);
      rd_reg(1, 8'hA8);
      $display("trigger test done");
      // Free run: the start bit launches the chain, each completion restarts it
      rd_reg(2, 8'h40);
      t1 = $time;
      wr_reg(1, 8'hE8);
      wait_irq(t1, 26);
      rd_reg(1, 8'hF8);
      rd_reg(5, 8'h03);
      rd_reg(3, 8'hA9);
      $display("free run test done");
      results();
   end
endmodule
